//--- ets_defs.svh
// Purpose: Shared constants for the transmit statistics and receive control slice
// Assumes: Lengths count bytes of a whole frame, FCS included
// Notes:   Register offsets are byte addresses on the APB
`ifndef ETS_DEFS_SVH
`define ETS_DEFS_SVH

`define ETS_LEN_W       16
`define ETS_BIN_N       5
`define ETS_BIN0_LO     16'h05f3
`define ETS_BIN0_HI     16'h060c
`define ETS_BIN1_LO     16'h060d
`define ETS_BIN1_HI     16'h07ff
`define ETS_BIN2_LO     16'h0800
`define ETS_BIN2_HI     16'h0fff
`define ETS_BIN3_LO     16'h1000
`define ETS_BIN3_HI     16'h1fff
`define ETS_BIN4_LO     16'h2000
`define ETS_BIN4_HI     16'h23ff
`define ETS_MIN_LEN     16'h0040
`define ETS_MAX_LEN     16'h23ff
`define ETS_STRIP_MIN   16'h0008
`define ETS_LEN_ONE     16'h0001
`define ETS_LEN_TWO     16'h0002
`define ETS_LEN_SAT     16'hffff
`define ETS_FCS_BYTES   3'h4
`define ETS_FILL_ONE    3'h1
`define ETS_FILL_ZERO   3'h0

`define ETS_ADDR_W      12
`define ETS_REG_CTRL    12'h000
`define ETS_REG_STATUS  12'h004
`define ETS_CTRL_W      3
`define ETS_CTRL_RST    3'h0
`define ETS_CTRL_RX_EN  0
`define ETS_CTRL_DELFCS 1
`define ETS_CTRL_TEST   2
`define ETS_ST_W        4
`define ETS_ST_LFAULT   0
`define ETS_ST_FIFOERR  1
`define ETS_ST_DECODE   2
`define ETS_ST_BUSY     3
`define ETS_ZERO32      32'h0000_0000
`define ETS_ZERO8       8'h00

`endif

//--- ets_pkg.sv
// Purpose: Types for the transmit statistics and receive control slice
// Assumes: Constants live in ets_defs.svh
// Notes:   Nothing here is imported; users write ets_pkg::name
`default_nettype none
package ets_pkg;
  typedef logic [7:0]  ets_byte_t;
  typedef logic [15:0] ets_len_t;
  typedef enum logic [1:0] {
    rx_idle,
    rx_pkt,
    rx_drain
  } ets_rx_state_t;
endpackage
`default_nettype wire

//--- ets_slice.sv
// Purpose: Transmit statistics strobes and receive enable, FCS strip, test control
// Assumes: Single pclk domain; receive data arrives one byte per cycle
// Notes:   APB slave with zero wait states; unmapped addresses answer pslverr
// What this block does
// RULE_01 - Strobe per packet of 1523-1548 bytes
// RULE_02 - Strobe per packet of 1549-2047 bytes
// RULE_03 - Strobe per packet of 2048-4095 bytes
// RULE_04 - Strobe per packet of 4096-8191 bytes
// RULE_05 - Strobe per packet of 8192-9215 bytes
// RULE_06 - Strobe per packet under 64 bytes
// RULE_07 - Strobe per packet over 9215 bytes
// RULE_08 - Strobe bad FCS on packets over 64
// RULE_09 - Strobe frame error on user-aborted packets
// RULE_10 - Local fault level while decoder initialises
// RULE_11 - FIFO error on compensation underflow or overflow
// RULE_12 - User resets port after FIFO error
// RULE_13 - Test control enables idle-pattern checking
// RULE_14 - User holds receive enable high normally
// RULE_15 - Disable finishes current packet, then stops decode
// RULE_16 - Disabled receive: no statistics, idle output
// RULE_17 - Strip off: FCS passes through
// RULE_18 - Strip on: FCS removed before delivery
// RULE_19 - Never strip packets of eight bytes or fewer
// RULE_20 - User changes strip only during reset
// RULE_21 - Each statistics strobe lasts one cycle
`timescale 1ns/1ps
`default_nettype none
`include "ets_defs.svh"
module ets_slice (
  input  wire logic                   pclk,                // 40 MHz clock
  input  wire logic                   presetn,             // Async reset, low
  input  wire logic                   psel,                // APB select
  input  wire logic                   penable,             // APB access phase
  input  wire logic                   pwrite,              // APB write
  input  wire logic [`ETS_ADDR_W-1:0] paddr,               // APB byte address
  input  wire logic [31:0]            pwdata,              // APB write data
  output logic      [31:0]            prdata,              // APB read data
  output logic                        pready,              // APB ready
  output logic                        pslverr,             // APB error
  input  wire logic                   tx_pkt_done,         // Packet sent strobe
  input  wire logic [`ETS_LEN_W-1:0]  tx_pkt_len,          // Its length
  input  wire logic                   tx_fcs_err,          // Its FCS was bad
  input  wire logic                   tx_abort,            // User aborted it
  input  wire logic                   tx_init_state,       // Decoder in init
  input  wire logic                   tx_comp_ovf,         // Comp FIFO overflow
  input  wire logic                   tx_comp_unf,         // Comp FIFO underflow
  output logic [`ETS_BIN_N-1:0]       stat_tx_bin,         // Length bins
  output logic                        stat_tx_small,       // Undersize
  output logic                        stat_tx_large,       // Oversize
  output logic                        stat_tx_bad_fcs,     // Bad FCS
  output logic                        stat_tx_frame_err,   // Aborted
  output logic                        stat_tx_local_fault, // Level
  output logic                        stat_tx_fifo_err,    // Sticky level
  input  wire logic                   rx_in_valid,         // Decoded byte valid
  input  wire logic [7:0]             rx_in_data,          // Decoded byte
  input  wire logic                   rx_in_sop,           // First byte
  input  wire logic                   rx_in_eop,           // Last byte
  output logic                        rx_in_ready,         // Byte taken
  output logic                        rx_out_valid,        // User byte valid
  output logic [7:0]                  rx_out_data,         // User byte
  output logic                        rx_out_sop,          // User first byte
  output logic                        rx_out_eop,          // User last byte
  output logic                        rx_decode_en,        // PCS may decode
  output logic                        rx_test_mode,        // Idle check on
  output logic                        stat_rx_pkt          // Packet received
);
  logic [`ETS_CTRL_W-1:0]    ctrl;
  logic [`ETS_ST_W-1:0]      status;
  logic                      addr_miss;
  logic                      wr_access;
  ets_pkg::ets_rx_state_t    state;
  ets_pkg::ets_byte_t        dly [4];
  logic [2:0]                fill;
  ets_pkg::ets_len_t         rx_len;
  ets_pkg::ets_len_t         next_len;
  logic                      first_out;
  logic                      strip_pkt;
  logic                      take;

  ets_stat_if stat_bus ();

  assign stat_bus.pkt_done = tx_pkt_done;
  assign stat_bus.pkt_len  = tx_pkt_len;
  assign stat_bus.fcs_err  = tx_fcs_err;
  assign stat_bus.abort    = tx_abort;

  ets_tx_stats u_tx_stats (
    .pclk       (pclk),
    .presetn    (presetn),
    .stat       (stat_bus.dst),
    .bin_strobe (stat_tx_bin),
    .small_pkt  (stat_tx_small),
    .large_pkt  (stat_tx_large),
    .bad_fcs    (stat_tx_bad_fcs),
    .frame_err  (stat_tx_frame_err)
  );

  // APB: never stalls, so pready is constant high
  assign pready    = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign pslverr   = psel && penable && addr_miss;

  always_comb begin
    status                  = '0;
    status[`ETS_ST_LFAULT]  = stat_tx_local_fault;
    status[`ETS_ST_FIFOERR] = stat_tx_fifo_err;
    status[`ETS_ST_DECODE]  = rx_decode_en;
    status[`ETS_ST_BUSY]    = (state != ets_pkg::rx_idle);
  end

  // Read data is captured in the setup cycle so it is a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata    <= `ETS_ZERO32;
      addr_miss <= 1'b0;
    end else if (psel && !penable) begin
      addr_miss <= 1'b0;
      unique case (paddr)
        `ETS_REG_CTRL:   prdata <= 32'(ctrl);
        `ETS_REG_STATUS: prdata <= 32'(status);
        default: begin
          prdata    <= `ETS_ZERO32;
          addr_miss <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `ETS_CTRL_RST;
    end else if (wr_access && paddr == `ETS_REG_CTRL) begin
      ctrl <= pwdata[`ETS_CTRL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_test_mode <= 1'b0;
    end else begin
      rx_test_mode <= ctrl[`ETS_CTRL_TEST]; // [RULE_13]
    end
  end

  // Transmit side levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_tx_local_fault <= 1'b0;
    end else begin
      stat_tx_local_fault <= tx_init_state; // [RULE_10]
    end
  end

  // Held until reset: the port is unusable after a slip anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_tx_fifo_err <= 1'b0;
    end else if (tx_comp_ovf || tx_comp_unf) begin
      stat_tx_fifo_err <= 1'b1; // [RULE_11] [RULE_12]
    end
  end

  // Receive path
  assign rx_in_ready = rx_decode_en && (state != ets_pkg::rx_drain);
  assign take        = rx_in_valid && rx_in_ready;
  assign next_len    = (state == ets_pkg::rx_idle) ? `ETS_LEN_ONE :
                       (rx_len == `ETS_LEN_SAT) ? rx_len : rx_len + `ETS_LEN_ONE;

  // Enable only changes between packets, so a packet is never cut short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_decode_en <= 1'b0;
    end else if (state == ets_pkg::rx_idle && !take) begin
      rx_decode_en <= ctrl[`ETS_CTRL_RX_EN]; // [RULE_15]
    end
  end

  // Strip choice is frozen per packet; a mid-packet change cannot tear a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strip_pkt <= 1'b0;
    end else if (take && state == ets_pkg::rx_idle) begin
      strip_pkt <= ctrl[`ETS_CTRL_DELFCS]; // [RULE_20]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_rx_pkt <= 1'b0;
    end else begin
      stat_rx_pkt <= take && rx_in_eop; // [RULE_16]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        dly[i] <= `ETS_ZERO8;
      end
    end else if (take) begin
      dly[0] <= rx_in_data;
      for (int i = 1; i < 4; i++) begin
        dly[i] <= dly[i-1];
      end
    end
  end

  // Four bytes are held back so the FCS can be dropped once the end is known
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= ets_pkg::rx_idle;
      fill         <= `ETS_FILL_ZERO;
      rx_len       <= '0;
      first_out    <= 1'b0;
      rx_out_valid <= 1'b0;
      rx_out_data  <= `ETS_ZERO8;
      rx_out_sop   <= 1'b0;
      rx_out_eop   <= 1'b0;
    end else begin
      rx_out_valid <= 1'b0;
      rx_out_sop   <= 1'b0;
      rx_out_eop   <= 1'b0;
      if (take) begin
        rx_len <= next_len;
        if (state == ets_pkg::rx_idle) begin
          first_out <= 1'b1;
        end
        if (fill == `ETS_FCS_BYTES) begin
          rx_out_valid <= 1'b1;
          rx_out_data  <= dly[3];
          rx_out_sop   <= first_out;
          first_out    <= 1'b0;
        end else begin
          fill <= fill + `ETS_FILL_ONE;
        end
        if (!rx_in_eop) begin
          state <= ets_pkg::rx_pkt;
        end else if (strip_pkt && next_len > `ETS_STRIP_MIN) begin
          rx_out_eop <= 1'b1; // [RULE_18]
          fill       <= `ETS_FILL_ZERO;
          state      <= ets_pkg::rx_idle;
        end else begin
          state <= ets_pkg::rx_drain; // [RULE_17] [RULE_19]
        end
      end else if (state == ets_pkg::rx_drain) begin
        rx_out_valid <= 1'b1;
        rx_out_data  <= dly[2'(fill - `ETS_FILL_ONE)];
        rx_out_sop   <= first_out;
        first_out    <= 1'b0;
        rx_out_eop   <= (fill == `ETS_FILL_ONE);
        fill         <= fill - `ETS_FILL_ONE;
        if (fill == `ETS_FILL_ONE) begin
          state <= ets_pkg::rx_idle;
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_long_end;
    take && rx_in_eop && strip_pkt && next_len > `ETS_STRIP_MIN;
  endsequence
  sequence s_keep_end;
    take && rx_in_eop && !strip_pkt && fill == `ETS_FCS_BYTES;
  endsequence
  sequence s_short_end;
    take && rx_in_eop && strip_pkt && next_len <= `ETS_STRIP_MIN
    && next_len >= `ETS_LEN_TWO;
  endsequence
  sequence s_go_quiet;
    state == ets_pkg::rx_idle && !take && !ctrl[`ETS_CTRL_RX_EN];
  endsequence

  // Skip the edge right after release: the flop was still held in reset there
  a_local_fault: assert property ( // [RULE_10]
    $past(presetn) |-> (stat_tx_local_fault == $past(tx_init_state)))
    else $error("local fault does not follow decoder init");
  a_fifo_err_hold: assert property ( // [RULE_11]
    (tx_comp_ovf || tx_comp_unf) |=> stat_tx_fifo_err ##1 stat_tx_fifo_err)
    else $error("FIFO error not raised or not held");
  a_test_ctrl: assert property ( // [RULE_13]
    (wr_access && paddr == `ETS_REG_CTRL) |=> ##1
    (rx_test_mode == $past(pwdata[`ETS_CTRL_TEST], 2)))
    else $error("test mode does not follow control");
  a_rx_stop: assert property ( // [RULE_15]
    s_go_quiet |=> !rx_decode_en && !rx_in_ready)
    else $error("receive not stopped when idle and disabled");
  a_rx_quiet: assert property ( // [RULE_16]
    (!rx_decode_en && state == ets_pkg::rx_idle) |=> !stat_rx_pkt && !rx_out_valid)
    else $error("activity while receive disabled");
  a_fcs_cut: assert property ( // [RULE_18]
    s_long_end |=> (rx_out_valid && rx_out_eop) ##1 !rx_out_valid)
    else $error("FCS not removed");
  a_fcs_kept: assert property ( // [RULE_17]
    s_keep_end |=> (rx_out_valid && !rx_out_eop) ##1 (rx_out_valid && !rx_out_eop) [*3]
    ##1 (rx_out_valid && rx_out_eop))
    else $error("FCS not passed through");
  a_short_kept: assert property ( // [RULE_19]
    s_short_end |=> !rx_out_eop ##[1:4] (rx_out_valid && rx_out_eop))
    else $error("short packet lost its FCS");
endmodule
`default_nettype wire

//--- ets_stat_counter.sv
// Purpose: User-side statistics counters fed by the slice strobes
// Assumes: Strobes are one-cycle pulses on pclk
// Notes:   A strobe held high would count again each cycle, as real counters do
`timescale 1ns/1ps
`default_nettype none
module ets_stat_counter (
  input  wire logic        pclk,    // Core clock
  input  wire logic        presetn, // Port reset, low
  input  wire logic [8:0]  strobe,  // Statistics pulses
  output logic      [15:0] cnt [9]  // Running counts
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '{default: 16'h0000};
    end else begin
      for (int i = 0; i < 9; i++) begin
        cnt[i] <= cnt[i] + {15'h0000, strobe[i]};
      end
    end
  end
endmodule
`default_nettype wire

//--- ets_stat_if.sv
// Purpose: Per-packet transmit status from the top to the statistics binner
// Assumes: pkt_done is a one-cycle strobe with the other fields valid with it
// Notes:   No clocking; both ends sit on pclk
`timescale 1ns/1ps
`default_nettype none
interface ets_stat_if;
  logic               pkt_done;
  ets_pkg::ets_len_t  pkt_len;
  logic               fcs_err;
  logic               abort;
  modport src (output pkt_done, output pkt_len, output fcs_err, output abort);
  modport dst (input pkt_done, input pkt_len, input fcs_err, input abort);
endinterface
`default_nettype wire

//--- ets_tx_stats.sv
// Purpose: Turns one transmit packet report into one-cycle statistics strobes
// Assumes: At most one report per cycle
// Notes:   Strobes are registered, one cycle after the report
`timescale 1ns/1ps
`default_nettype none
`include "ets_defs.svh"
module ets_tx_stats (
  input  wire logic              pclk,        // Core clock
  input  wire logic              presetn,     // Async reset, low
  ets_stat_if.dst                stat,        // Packet report
  output logic [`ETS_BIN_N-1:0]  bin_strobe,  // Long-length bins
  output logic                   small_pkt,   // Under 64 bytes
  output logic                   large_pkt,   // Over 9215 bytes
  output logic                   bad_fcs,     // Over 64 bytes with FCS error
  output logic                   frame_err    // Aborted by user
);
  localparam ets_pkg::ets_len_t BIN_LO [`ETS_BIN_N] = '{`ETS_BIN0_LO, `ETS_BIN1_LO,
    `ETS_BIN2_LO, `ETS_BIN3_LO, `ETS_BIN4_LO};
  localparam ets_pkg::ets_len_t BIN_HI [`ETS_BIN_N] = '{`ETS_BIN0_HI, `ETS_BIN1_HI,
    `ETS_BIN2_HI, `ETS_BIN3_HI, `ETS_BIN4_HI};

  logic [`ETS_BIN_N-1:0] hit;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  for (genvar g = 0; g < `ETS_BIN_N; g++) begin : g_bin
    // Good and bad packets alike land in their bin
    assign hit[g] = stat.pkt_done && (stat.pkt_len >= BIN_LO[g])
                    && (stat.pkt_len <= BIN_HI[g]); // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_05]
    a_bin_strobe: assert property ( // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_05]
      (stat.pkt_done && stat.pkt_len >= BIN_LO[g] && stat.pkt_len <= BIN_HI[g])
      |=> bin_strobe[g])
      else $error("length bin strobe missed");
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bin_strobe <= '0;
      small_pkt  <= 1'b0;
      large_pkt  <= 1'b0;
      bad_fcs    <= 1'b0;
      frame_err  <= 1'b0;
    end else begin
      bin_strobe <= hit; // [RULE_21]
      small_pkt  <= stat.pkt_done && (stat.pkt_len < `ETS_MIN_LEN); // [RULE_06]
      large_pkt  <= stat.pkt_done && (stat.pkt_len > `ETS_MAX_LEN); // [RULE_07]
      bad_fcs    <= stat.pkt_done && stat.fcs_err
                    && (stat.pkt_len > `ETS_MIN_LEN); // [RULE_08]
      frame_err  <= stat.pkt_done && stat.abort; // [RULE_09]
    end
  end

  a_small_strobe: assert property ( // [RULE_06]
    stat.pkt_done |=> (small_pkt == ($past(stat.pkt_len) < `ETS_MIN_LEN)))
    else $error("undersize strobe wrong");
  a_large_strobe: assert property ( // [RULE_07]
    stat.pkt_done |=> (large_pkt == ($past(stat.pkt_len) > `ETS_MAX_LEN)))
    else $error("oversize strobe wrong");
  a_bad_fcs: assert property ( // [RULE_08]
    (stat.pkt_done && stat.fcs_err && stat.pkt_len == `ETS_MIN_LEN) |=> !bad_fcs)
    else $error("bad FCS counted at 64 bytes");
  a_frame_err: assert property ( // [RULE_09]
    frame_err |-> $past(stat.pkt_done && stat.abort))
    else $error("frame error without abort");
  // A cycle with no report must leave every strobe low, so no pulse runs on
  a_pulse_once: assert property ( // [RULE_21]
    !stat.pkt_done |=> !(|bin_strobe || small_pkt || large_pkt || bad_fcs || frame_err))
    else $error("strobe without a packet report");
endmodule
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the transmit statistics and receive control slice
// Assumes: Zero-wait APB; strobes lag their report by one cycle
// Notes:   Fixed seed; user counters compared with the bench model after the transmit run
`timescale 1ns/1ps
`default_nettype none
`include "ets_defs.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        tx_pkt_done, tx_fcs_err, tx_abort, tx_init_state, tx_comp_ovf, tx_comp_unf;
  logic [15:0] tx_pkt_len;
  logic [4:0]  stat_tx_bin;
  logic        stat_tx_small, stat_tx_large, stat_tx_bad_fcs, stat_tx_frame_err;
  logic        stat_tx_local_fault, stat_tx_fifo_err, stat_rx_pkt, rx_decode_en, rx_test_mode;
  logic        rx_in_valid, rx_in_sop, rx_in_eop, rx_in_ready;
  logic        rx_out_valid, rx_out_sop, rx_out_eop;
  logic [7:0]  rx_in_data, rx_out_data;
  logic [8:0]  strb;
  logic [15:0] cnt [9];
  logic [9:0]  oq [$];
  int          fail_count, check_count, rx_pkts;
  int          mcnt [9];
  int          lens [16] = '{63, 64, 65, 1522, 1523, 1548, 1549, 2047, 2048, 4095, 4096,
                             8191, 8192, 9215, 9216, 65535};
  int          plen [3] = '{8, 9, 20};

  assign strb = {stat_tx_frame_err, stat_tx_bad_fcs, stat_tx_large, stat_tx_small, stat_tx_bin};

  ets_slice u_ets_slice (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .tx_pkt_done, .tx_pkt_len, .tx_fcs_err, .tx_abort, .tx_init_state,
    .tx_comp_ovf, .tx_comp_unf, .stat_tx_bin, .stat_tx_small, .stat_tx_large,
    .stat_tx_bad_fcs, .stat_tx_frame_err, .stat_tx_local_fault, .stat_tx_fifo_err,
    .rx_in_valid, .rx_in_data, .rx_in_sop, .rx_in_eop, .rx_in_ready, .rx_out_valid,
    .rx_out_data, .rx_out_sop, .rx_out_eop, .rx_decode_en, .rx_test_mode, .stat_rx_pkt
  );
  ets_stat_counter u_ets_stat_counter (.pclk, .presetn, .strobe(strb), .cnt(cnt));

  always #12.5 pclk = ~pclk;

  // Sampled at the edge, so each output byte is seen once with its flags
  always @(posedge pclk) begin
    if (rx_out_valid === 1'b1) oq.push_back({rx_out_sop, rx_out_eop, rx_out_data});
    if (stat_rx_pkt === 1'b1) rx_pkts++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_count++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rst();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  function automatic logic [8:0] exp_stat(int len, logic fe, logic ab);
    logic [8:0] e;
    e[0] = len >= 1523 && len <= 1548;
    e[1] = len >= 1549 && len <= 2047;
    e[2] = len >= 2048 && len <= 4095;
    e[3] = len >= 4096 && len <= 8191;
    e[4] = len >= 8192 && len <= 9215;
    e[5] = len < 64;
    e[6] = len > 9215;
    e[7] = len > 64 && fe;
    e[8] = ab;
    return e;
  endfunction

  // Reports mostly back to back, with random gaps and random init level
  task automatic tx_run(input int n);
    logic [8:0] prv, e;
    logic       pin, ini, dn, fe, ab;
    int         len;
    prv = 9'h000;
    pin = 1'b0;
    for (int i = 0; i <= n; i++) begin
      len = (i < 16) ? lens[i] : $urandom_range(12000);
      dn  = (i < n) && (i < 16 || $urandom_range(3) != 0);
      // The 64-byte report always carries a bad FCS, so the boundary is exercised
      fe  = (i == 1) || $urandom_range(1);
      ab  = $urandom_range(1);
      ini = $urandom_range(1);
      e   = dn ? exp_stat(len, fe, ab) : 9'h000;
      tx_pkt_done   <= dn;
      tx_pkt_len    <= 16'(len);
      tx_fcs_err    <= fe;
      tx_abort      <= ab;
      tx_init_state <= ini;
      #1;
      chk(strb[4:0], prv[4:0]);
      chk(strb[8:5], prv[8:5]);
      chk(stat_tx_local_fault, pin);
      for (int j = 0; j < 9; j++) mcnt[j] += e[j];
      prv = e;
      pin = ini;
      @(posedge pclk);
    end
  endtask

  task automatic rx_send(input int len, input logic strip);
    logic [7:0] d [$];
    logic       t;
    int         i, n, m;
    i = 0;
    n = 0;
    m = (strip && len > 8) ? len - 4 : len;
    oq.delete();
    repeat (len) d.push_back(8'($urandom_range(255)));
    while (i < len && n < 500) begin
      rx_in_valid <= 1'b1;
      rx_in_data  <= d[i];
      rx_in_sop   <= (i == 0);
      rx_in_eop   <= (i == len - 1);
      @(negedge pclk);
      t = rx_in_ready;
      @(posedge pclk);
      n++;
      if (t === 1'b1) i++;
    end
    rx_in_valid <= 1'b0;
    rx_in_sop   <= 1'b0;
    rx_in_eop   <= 1'b0;
    repeat (12) @(posedge pclk);
    chk(i, len);
    chk(oq.size(), m);
    for (int k = 0; k < m && k < oq.size(); k++) begin
      chk(oq[k], {(k == 0), (k == m - 1), d[k]});
    end
  endtask

  initial begin
    #1_000_000;
    fail_count++;
    summarize();
  end

  initial begin
    logic [31:0] rd;
    logic        er;
    int          n0;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, tx_pkt_done, tx_fcs_err, tx_abort, tx_init_state} = 7'h00;
    {tx_comp_ovf, tx_comp_unf, rx_in_valid, rx_in_sop, rx_in_eop} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    tx_pkt_len = 16'h0000;
    rx_in_data = 8'h00;
    void'($urandom(27061));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `ETS_REG_CTRL, 32'h0000_0000, rd, er);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h00c, 32'h0000_0000, rd, er);
    chk({er, rd[30:0]}, 32'h8000_0000);
    tx_run(200);
    #1;
    for (int j = 0; j < 9; j++) chk({16'h0000, cnt[j]}, mcnt[j]);
    @(posedge pclk);
    for (int k = 0; k < 2; k++) begin
      tx_comp_ovf <= (k == 0);
      tx_comp_unf <= (k == 1);
      @(posedge pclk);
      tx_comp_ovf <= 1'b0;
      tx_comp_unf <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, `ETS_REG_STATUS, 32'h0000_0000, rd, er);
      chk({stat_tx_fifo_err, rd[`ETS_ST_FIFOERR]}, 32'h0000_0003);
      rst(); // Only a port reset clears it
      chk(stat_tx_fifo_err, 1'b0);
    end
    for (int s = 0; s < 2; s++) begin
      rst(); // Strip only changed across a port reset
      apb(1'b1, `ETS_REG_CTRL, 32'(1 + 2 * s), rd, er);
      repeat (3) @(posedge pclk);
      chk(rx_decode_en, 1'b1);
      foreach (plen[j]) rx_send(plen[j], s[0]);
    end
    chk(rx_pkts, 6);
    fork
      rx_send(30, 1'b1);
      begin
        repeat (10) @(posedge pclk);
        apb(1'b1, `ETS_REG_CTRL, 32'h0000_0002, rd, er);
      end
    join
    chk({rx_decode_en, rx_in_ready}, 32'h0000_0000);
    n0 = rx_pkts;
    oq.delete();
    rx_in_valid <= 1'b1;
    repeat (10) @(posedge pclk);
    rx_in_valid <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(oq.size(), 0);
    chk(rx_pkts, n0);
    apb(1'b1, `ETS_REG_CTRL, 32'h0000_0004, rd, er);
    repeat (2) @(posedge pclk);
    chk(rx_test_mode, 1'b1);
    apb(1'b1, `ETS_REG_CTRL, 32'h0000_0000, rd, er);
    repeat (2) @(posedge pclk);
    chk(rx_test_mode, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
